// file: hw/link_ctrl_pkg.sv
// constants and types for the serializer link control register slice
//
// Overview of operation
// R1 - pass-all clear forwards only remote ids; set forwards all except own id
// R2 - sda input held after scl by hold field times 40 ns
// R3 - scl and sda glitches up to filter field times 5 ns are rejected
// R4 - master scl high lasts at least 38.0952 ns times (high count + 5); reset 0xa1
// R5 - master scl low lasts at least 38.0952 ns times (low count + 5); reset 0xa5
// R6 - as stretching target, low count sets sda setup before scl release
// R7 - wide-word clear: 24 data bits plus de, hs, vs; set: 28 data bits
// R8 - surround set carries 5.1 or 7.1 audio, else 2 or 4 channels
// R9 - surround audio only with data-island transport, never frame transport
// R10 - in a repeater, in-band detected mode may override the surround bit
// R11 - self-test back-channel crc errors counted, saturating at 255, cleared on start
// R12 - secondary port select makes the error count show the second port
// R13 - gpio input levels readable at 0x1c bits 7,6,5,3:0 and 0x1d bit 0
// R14 - secondary port select shows second-port pins 3:0 and steers their config
// R15 - second-address enable makes device also answer own id plus one
// R16 - host sets second-address enable to reach remote devices over second link
// R17 - secondary select routes primary accesses to port 1; ignored with second address
// R18 - primary select writes port 0; reads show port 1 if both selects set
// R19 - both selects ignored under second-address enable; port select resets 0x01
// R20 - writing n counts pixel clock edges over n oscillator periods, freezing 0xff
// R21 - channel-b enable with its override allows the second audio input
// R22 - reserved bits read zero and ignore writes
package link_ctrl_pkg;

  // ------
  // register offsets
  // ------
  localparam logic [7:0] ADDR_FWD_CTRL = 8'h17;
  localparam logic [7:0] ADDR_SCL_HIGH = 8'h18;
  localparam logic [7:0] ADDR_SCL_LOW  = 8'h19;
  localparam logic [7:0] ADDR_DP_CTRL2 = 8'h1a;
  localparam logic [7:0] ADDR_BC_ERR   = 8'h1b;
  localparam logic [7:0] ADDR_PIN_LOW  = 8'h1c;
  localparam logic [7:0] ADDR_PIN_HIGH = 8'h1d;
  localparam logic [7:0] ADDR_PORT_SEL = 8'h1e;
  localparam logic [7:0] ADDR_FREQ     = 8'h1f;

  // ------
  // reset values and writable masks
  // ------
  localparam logic [7:0] RST_FWD_CTRL  = 8'h1e;
  localparam logic [7:0] RST_SCL_HIGH  = 8'ha1;
  localparam logic [7:0] RST_SCL_LOW   = 8'ha5;
  localparam logic [7:0] RST_DP_CTRL2  = 8'h00;
  localparam logic [7:0] RST_PORT_SEL  = 8'h01;
  localparam logic [7:0] RST_FREQ      = 8'h00;
  localparam logic [7:0] MASK_DP_CTRL2 = 8'h03;
  localparam logic [7:0] MASK_PORT_SEL = 8'h07;

  // ------
  // field positions
  // ------
  localparam int FWD_PASS_ALL_BIT   = 7;
  localparam int HOLD_LSB           = 4;
  localparam int FILTER_LSB         = 0;
  localparam int DP_WIDE_BIT        = 1;
  localparam int DP_SURROUND_BIT    = 0;
  localparam int PS_SECOND_ADDR_BIT = 2;
  localparam int PS_SECONDARY_BIT   = 1;
  localparam int PS_PRIMARY_BIT     = 0;

  // ------
  // timing
  // ------
  localparam int CLK_PERIOD_NS     = 20;
  localparam int OSC_PERIOD_NS     = 40;
  localparam int FILTER_UNIT_NS    = 5;
  localparam int HOLD_UNIT_NS      = 40;
  localparam int SCL_EXTRA_PERIODS = 5;
  localparam int OSC_CYCLES        = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int HOLD_CYCLES       = HOLD_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] COUNT_SAT = 8'hff;

  typedef enum logic [1:0] {
    SCL_IDLE = 2'b00,
    SCL_HIGH = 2'b01,
    SCL_LOW  = 2'b10
  } scl_state_t;

endpackage

// file: hw/link_ctrl_if.sv
// interfaces between the register slice and its timing and counter helpers
`timescale 1ns/100ps
interface i2c_cfg_if;
  logic [3:0] filterDepth;
  logic [2:0] holdTime;
  logic [7:0] highCount;
  logic [7:0] lowCount;
  modport ctrl   (output filterDepth, holdTime, highCount, lowCount);
  modport timing (input  filterDepth, holdTime, highCount, lowCount);
endinterface

interface freq_if;
  logic       start;
  logic [7:0] interval;
  logic [7:0] count;
  modport ctrl    (output start, interval, input  count);
  modport counter (input  start, interval, output count);
endinterface

// file: hw/i2c_timing.sv
// i2c pin filter, sda hold, master scl generator and target setup stretch
`timescale 1ns/100ps
module i2c_timing (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // configuration
  i2c_cfg_if.timing cfg,
  // pins
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sclOut,
  output logic      sclOe,
  // core side
  input  wire logic masterEn,
  input  wire logic stretchReq,
  output logic      sclFilt,
  output logic      sdaFilt
);
  import link_ctrl_pkg::*;

  function automatic logic [2:0] filterCycles(input logic [3:0] depth);
    int ns;
    ns = int'(depth) * FILTER_UNIT_NS;
    return 3'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  function automatic logic [9:0] sclCycles(input logic [7:0] cnt);
    return 10'((int'(cnt) + SCL_EXTRA_PERIODS) * OSC_CYCLES);
  endfunction

  // ------
  // synchronise and deglitch both pins
  // ------
  logic [1:0] pinIn;
  logic [1:0] pinFilt;
  assign pinIn = {sdaIn, sclIn};

  for (genvar g = 0; g < 2; g++) begin : gFilt
    logic [2:0] sync_q;
    logic       filt_q;
    logic [2:0] cnt_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        sync_q <= 3'h7;
      end else begin
        sync_q <= {sync_q[1:0], pinIn[g]};
      end
    end
    // a pulse no wider than the depth never reaches filt_q
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        filt_q <= 1'b1;
        cnt_q  <= 3'h0;
      end else if (sync_q[1] != sync_q[2] || sync_q[2] == filt_q) begin
        cnt_q <= 3'h0;
      end else if (cnt_q >= filterCycles(cfg.filterDepth)) begin // [R3]
        filt_q <= sync_q[2];
        cnt_q  <= 3'h0;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
    assign pinFilt[g] = filt_q;
  end

  // ------
  // sda hold after scl falls
  // ------
  logic       sclPrev_q;
  logic [3:0] holdCnt_q;
  logic       sdaHeld_q;
  logic       sclFall;
  assign sclFall = sclPrev_q & ~pinFilt[0];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclPrev_q <= 1'b1;
      holdCnt_q <= 4'h0;
      sdaHeld_q <= 1'b1;
    end else begin
      sclPrev_q <= pinFilt[0];
      if (sclFall) begin
        holdCnt_q <= 4'(int'(cfg.holdTime) * HOLD_CYCLES); // [R2]
      end else if (holdCnt_q != 4'h0) begin
        holdCnt_q <= holdCnt_q - 4'h1;
      end else begin
        sdaHeld_q <= pinFilt[1];
      end
    end
  end
  assign sclFilt = pinFilt[0];
  assign sdaFilt = sdaHeld_q;

  // ------
  // master scl and target setup stretch
  // ------
  scl_state_t state_q;
  logic [9:0] phase_q;
  logic [9:0] setup_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SCL_IDLE;
      phase_q <= 10'h000;
    end else begin
      case (state_q)
        SCL_IDLE: begin
          if (masterEn) begin
            state_q <= SCL_HIGH;
            phase_q <= sclCycles(cfg.highCount); // [R4]
          end
        end
        SCL_HIGH: begin
          phase_q <= phase_q - 10'h001;
          if (phase_q <= 10'h001) begin
            state_q <= SCL_LOW;
            phase_q <= sclCycles(cfg.lowCount); // [R5]
          end
        end
        SCL_LOW: begin
          phase_q <= phase_q - 10'h001;
          if (phase_q <= 10'h001) begin
            state_q <= masterEn ? SCL_HIGH : SCL_IDLE;
            phase_q <= sclCycles(cfg.highCount); // [R4]
          end
        end
        default: begin
          state_q <= SCL_IDLE;
        end
      endcase
    end
  end

  // data is already on sda while stretch is held; keep scl low one setup time more
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      setup_q <= 10'h000;
    end else if (stretchReq) begin
      setup_q <= sclCycles(cfg.lowCount); // [R6]
    end else if (setup_q != 10'h000) begin
      setup_q <= setup_q - 10'h001;
    end
  end

  assign sclOut = 1'b0;
  assign sclOe  = (state_q == SCL_LOW) | stretchReq | (setup_q != 10'h000);
endmodule

// file: hw/freq_counter.sv
// pixel clock edge counter over a programmed oscillator interval
`timescale 1ns/100ps
module freq_counter (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // pixel clock pin
  input  wire logic pixelClk,
  // control
  freq_if.counter   fq
);
  import link_ctrl_pkg::*;

  logic [2:0] sync_q;
  logic       run_q;
  logic [8:0] timer_q;
  logic [7:0] count_q;
  logic       rise;

  // sampled clock: only rough for pixel clocks near or above half core_clk
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], pixelClk};
    end
  end
  assign rise = sync_q[1] & ~sync_q[2];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q   <= 1'b0;
      timer_q <= 9'h000;
      count_q <= 8'h00;
    end else if (fq.start) begin
      run_q   <= fq.interval != 8'h00;
      timer_q <= 9'(int'(fq.interval) * OSC_CYCLES); // [R20]
      count_q <= 8'h00;
    end else if (run_q) begin
      timer_q <= timer_q - 9'h001;
      if (timer_q == 9'h001) begin
        run_q <= 1'b0;
      end
      if (rise && count_q != COUNT_SAT) begin // [R20]
        count_q <= count_q + 8'h01;
      end
    end
  end
  assign fq.count = count_q;
endmodule

// file: hw/serializer_link_control_regs.sv
// control register slice 0x17 to 0x1f with its forwarding, audio and port logic
`timescale 1ns/100ps
module serializer_link_control_regs (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // register access from the i2c target
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic       viaSecondAddr,
  output logic      [7:0] regRdData,
  // target address matching and forwarding
  input  wire logic [6:0] accessId,
  input  wire logic [6:0] deviceId,
  input  wire logic [6:0] remoteDesId,
  input  wire logic [6:0] remoteTargetId,
  output logic            isOwnPrimary,
  output logic            isOwnSecond,
  output logic            forwardAccess,
  // port routing for other register slices
  output logic            wrPort0En,
  output logic            wrPort1En,
  output logic            rdPort1,
  output logic            gpioCfgPort1,
  // i2c pins
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       masterEn,
  input  wire logic       stretchReq,
  output logic            sclFiltered,
  output logic            sdaFiltered,
  // video and audio
  input  wire logic       chanBEnable,
  input  wire logic       chanBOverride,
  input  wire logic       frameTransportSel,
  input  wire logic       repeaterMode,
  input  wire logic       inbandModeValid,
  input  wire logic       inbandSurround,
  output logic            wideWordMode,
  output logic            lowSpeedCtrlEn,
  output logic            surroundActive,
  output logic            fourChannelActive,
  // self-test
  input  wire logic       bistActive,
  input  wire logic       bistStart,
  input  wire logic       errClear,
  input  wire logic [1:0] bcCrcErr,
  // gpio pins: primary 3:0, second port 3:0, register-only 5..8
  input  wire logic [3:0] pinsPrimary,
  input  wire logic [3:0] pinsSecond,
  input  wire logic [3:0] pinsRegOnly,
  // pixel clock pin
  input  wire logic       pixelClk
);
  import link_ctrl_pkg::*;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  // ------
  // registers
  // ------
  logic [7:0] fwdCtrl_q;
  logic [7:0] sclHigh_q;
  logic [7:0] sclLow_q;
  logic [7:0] dpCtrl2_q;
  logic [7:0] portSel_q;
  logic [7:0] freq_q;
  logic       freqStart_q;
  logic       wr;

  assign wr = regWrEn;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fwdCtrl_q <= RST_FWD_CTRL;
      sclHigh_q <= RST_SCL_HIGH;
      sclLow_q  <= RST_SCL_LOW;
    end else if (wr) begin
      if (hit(regAddr, ADDR_FWD_CTRL)) begin
        fwdCtrl_q <= regWrData;
      end else if (hit(regAddr, ADDR_SCL_HIGH)) begin
        sclHigh_q <= regWrData;
      end else if (hit(regAddr, ADDR_SCL_LOW)) begin
        sclLow_q <= regWrData;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      portSel_q <= RST_PORT_SEL; // [R19]
    end else if (wr && hit(regAddr, ADDR_PORT_SEL)) begin
      portSel_q <= regWrData & MASK_PORT_SEL; // [R22]
    end
  end

  // in-band detection in a repeater wins over a software write
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dpCtrl2_q <= RST_DP_CTRL2;
    end else begin
      if (wr && hit(regAddr, ADDR_DP_CTRL2)) begin
        dpCtrl2_q <= regWrData & MASK_DP_CTRL2; // [R22]
      end
      if (repeaterMode && inbandModeValid) begin
        dpCtrl2_q[DP_SURROUND_BIT] <= inbandSurround; // [R10]
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_q      <= RST_FREQ;
      freqStart_q <= 1'b0;
    end else begin
      freqStart_q <= wr && hit(regAddr, ADDR_FREQ);
      if (wr && hit(regAddr, ADDR_FREQ)) begin
        freq_q <= regWrData; // [R20]
      end
    end
  end

  // ------
  // port selection
  // ------
  logic secondAddrEn;
  logic secondarySel;
  logic primarySel;
  assign secondAddrEn = portSel_q[PS_SECOND_ADDR_BIT];
  assign secondarySel = portSel_q[PS_SECONDARY_BIT];
  assign primarySel   = portSel_q[PS_PRIMARY_BIT];

  // with a second address each address reaches one port only
  always_comb begin
    if (secondAddrEn) begin
      wrPort0En = ~viaSecondAddr; // [R19]
      wrPort1En = viaSecondAddr; // [R15]
      rdPort1   = viaSecondAddr; // [R17]
    end else begin
      wrPort0En = primarySel; // [R18]
      wrPort1En = secondarySel; // [R17]
      rdPort1   = secondarySel; // [R18]
    end
  end
  assign gpioCfgPort1 = rdPort1; // [R14]

  // ------------------------------------------------------------------
  // address match and forwarding
  // ------------------------------------------------------------------
  always_comb begin
    isOwnPrimary = accessId == deviceId;
    isOwnSecond  = secondAddrEn && (accessId == 7'(deviceId + 7'h01)); // [R15]
    if (isOwnPrimary || isOwnSecond) begin
      forwardAccess = 1'b0;
    end else if (fwdCtrl_q[FWD_PASS_ALL_BIT]) begin
      forwardAccess = 1'b1; // [R1]
    end else begin
      forwardAccess = (accessId == remoteDesId) || (accessId == remoteTargetId); // [R1]
    end
  end

  // ------------------------------------------------------------------
  // video and audio modes
  // ------------------------------------------------------------------
  assign wideWordMode   = dpCtrl2_q[DP_WIDE_BIT]; // [R7]
  assign lowSpeedCtrlEn = ~dpCtrl2_q[DP_WIDE_BIT]; // [R7]

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      surroundActive    <= 1'b0;
      fourChannelActive <= 1'b0;
    end else begin
      // frame transport cannot carry surround, so it is withheld there
      surroundActive    <= dpCtrl2_q[DP_SURROUND_BIT] & ~frameTransportSel; // [R8] [R9]
      fourChannelActive <= ~dpCtrl2_q[DP_SURROUND_BIT]
                           & chanBOverride & chanBEnable; // [R8] [R21]
    end
  end

  // ------------------------------------------------------------------
  // self-test error counters, one per port
  // ------------------------------------------------------------------
  logic [7:0] errCnt [2];
  logic       errRestart;
  assign errRestart = bistStart | errClear;

  for (genvar p = 0; p < 2; p++) begin : gErr
    logic [7:0] cnt_q;
    // an error in the clearing cycle is kept as the first count
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        cnt_q <= 8'h00;
      end else if (errRestart) begin
        cnt_q <= {7'h00, bistActive & bcCrcErr[p]}; // [R11]
      end else if (bistActive && bcCrcErr[p] && cnt_q != COUNT_SAT) begin
        cnt_q <= cnt_q + 8'h01; // [R11]
      end
    end
    assign errCnt[p] = cnt_q;
  end

  // ------------------------------------------------------------------
  // gpio input status
  // ------------------------------------------------------------------
  logic [11:0] pinRaw;
  logic [11:0] pinLvl;
  assign pinRaw = {pinsRegOnly, pinsSecond, pinsPrimary};

  for (genvar k = 0; k < 12; k++) begin : gPin
    logic [2:0] sync_q;
    logic       lvl_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        sync_q <= 3'h0;
      end else begin
        sync_q <= {sync_q[1:0], pinRaw[k]};
      end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        lvl_q <= 1'b0;
      end else if (sync_q[1] == sync_q[2]) begin
        lvl_q <= sync_q[2];
      end
    end
    assign pinLvl[k] = lvl_q;
  end

  logic [7:0] pinLow;
  logic [7:0] pinHigh;
  always_comb begin
    pinLow  = {pinLvl[10:8], 1'b0, // [R13] [R22]
               rdPort1 ? pinLvl[7:4] : pinLvl[3:0]}; // [R14]
    pinHigh = {7'h00, pinLvl[11]}; // [R13]
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  i2c_cfg_if cfgBus ();
  freq_if    freqBus ();

  assign cfgBus.filterDepth = fwdCtrl_q[FILTER_LSB +: 4]; // [R3]
  assign cfgBus.holdTime    = fwdCtrl_q[HOLD_LSB +: 3]; // [R2]
  assign cfgBus.highCount   = sclHigh_q;
  assign cfgBus.lowCount    = sclLow_q;
  assign freqBus.start      = freqStart_q;
  assign freqBus.interval   = freq_q;

  i2c_timing uTiming (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .cfg        (cfgBus.timing),
    .sclIn      (sclIn),
    .sdaIn      (sdaIn),
    .sclOut     (sclOut),
    .sclOe      (sclOe),
    .masterEn   (masterEn),
    .stretchReq (stretchReq),
    .sclFilt    (sclFiltered),
    .sdaFilt    (sdaFiltered)
  );

  freq_counter uFreq (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pixelClk (pixelClk),
    .fq       (freqBus.counter)
  );

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      if (hit(regAddr, ADDR_FWD_CTRL)) begin
        regRdData <= fwdCtrl_q;
      end else if (hit(regAddr, ADDR_SCL_HIGH)) begin
        regRdData <= sclHigh_q;
      end else if (hit(regAddr, ADDR_SCL_LOW)) begin
        regRdData <= sclLow_q;
      end else if (hit(regAddr, ADDR_DP_CTRL2)) begin
        regRdData <= dpCtrl2_q;
      end else if (hit(regAddr, ADDR_BC_ERR)) begin
        regRdData <= rdPort1 ? errCnt[1] : errCnt[0]; // [R12]
      end else if (hit(regAddr, ADDR_PIN_LOW)) begin
        regRdData <= pinLow;
      end else if (hit(regAddr, ADDR_PIN_HIGH)) begin
        regRdData <= pinHigh;
      end else if (hit(regAddr, ADDR_PORT_SEL)) begin
        regRdData <= portSel_q;
      end else if (hit(regAddr, ADDR_FREQ)) begin
        regRdData <= freqBus.count; // [R20]
      end else begin
        regRdData <= 8'h00;
      end
    end
  end
endmodule

// file: sim/pixel_src.sv
// free-running pixel clock source for the frequency counter
`timescale 1ns/100ps
module pixel_src (
  // pixel clock pin
  output logic pixelClk
);
  // 10 MHz, phase unrelated to core_clk
  initial begin
    pixelClk = 1'b0;
    #5;
    forever #50 pixelClk = ~pixelClk;
  end
endmodule

// file: sim/link_ctrl_chk.sv
// port assertions for the link control register slice
`timescale 1ns/100ps
module link_ctrl_chk (
  // watched ports
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic [6:0] accessId,
  input wire logic [6:0] deviceId,
  input wire logic [6:0] remoteDesId,
  input wire logic       isOwnPrimary,
  input wire logic       isOwnSecond,
  input wire logic       forwardAccess,
  input wire logic       rdPort1,
  input wire logic       gpioCfgPort1,
  input wire logic       stretchReq,
  input wire logic       sclOe,
  input wire logic       frameTransportSel,
  input wire logic       wideWordMode,
  input wire logic       lowSpeedCtrlEn,
  input wire logic       surroundActive
);
  // ------
  // properties
  // ------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_own_match: assert property (isOwnPrimary == (accessId == deviceId))
    else $error("own id match wrong");
  chk_own_kept: assert property (isOwnPrimary |-> !forwardAccess)
    else $error("own access forwarded");
  chk_remote_fwd: assert property (
    (accessId == remoteDesId) && !isOwnPrimary |-> forwardAccess)
    else $error("remote access not forwarded");
  chk_second_id: assert property (isOwnSecond |-> accessId == 7'(deviceId + 7'h01))
    else $error("second address wrong");
  chk_wide_ctrl: assert property (lowSpeedCtrlEn != wideWordMode)
    else $error("control bits with wide word");
  chk_frame_surr: assert property (frameTransportSel |=> !surroundActive)
    else $error("surround with frame transport");
  chk_gpio_steer: assert property (gpioCfgPort1 == rdPort1)
    else $error("gpio config port wrong");
  chk_stretch_pull: assert property (stretchReq |-> sclOe)
    else $error("scl not held in stretch");
  cover property (forwardAccess && !isOwnPrimary);
  cover property (surroundActive);
  cover property ($rose(sclOe));
  cover property (isOwnSecond);
endmodule

// file: sim/serializer_link_control_regs_tb.sv
// self-checking bench for the link control register slice
`timescale 1ns/100ps
module serializer_link_control_regs_tb;
  // ------
  // signals
  // ------
  logic       core_clk, rst_b, regWrEn, regRdEn, viaSecondAddr, pixelClk;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [6:0] accessId, deviceId, remoteDesId, remoteTargetId;
  logic       isOwnPrimary, isOwnSecond, forwardAccess, wrPort0En, wrPort1En;
  logic       rdPort1, gpioCfgPort1, sclOut, sclOe, sclIn, sdaIn, masterEn;
  logic       stretchReq, sclFiltered, sdaFiltered, chanBEnable, chanBOverride;
  logic       frameTransportSel, repeaterMode, inbandModeValid, inbandSurround;
  logic       wideWordMode, lowSpeedCtrlEn, surroundActive, fourChannelActive;
  logic       bistActive, bistStart, errClear;
  logic [1:0] bcCrcErr;
  logic [3:0] pinsPrimary, pinsSecond, pinsRegOnly;
  int         fails = 0;
  int         check_count = 0;
  logic [7:0] rstVal [9] = '{8'h1e, 8'ha1, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  // open drain: pull-up wins unless the slice pulls low
  assign sclIn = !sclOe;
  serializer_link_control_regs i_dut (.core_clk, .rst_b, .regAddr, .regWrData, .regWrEn,
    .regRdEn, .viaSecondAddr, .regRdData, .accessId, .deviceId, .remoteDesId, .remoteTargetId,
    .isOwnPrimary, .isOwnSecond, .forwardAccess, .wrPort0En, .wrPort1En, .rdPort1,
    .gpioCfgPort1, .sclIn, .sdaIn, .sclOut, .sclOe, .masterEn, .stretchReq, .sclFiltered,
    .sdaFiltered, .chanBEnable, .chanBOverride, .frameTransportSel, .repeaterMode,
    .inbandModeValid, .inbandSurround, .wideWordMode, .lowSpeedCtrlEn, .surroundActive,
    .fourChannelActive, .bistActive, .bistStart, .errClear, .bcCrcErr, .pinsPrimary,
    .pinsSecond, .pinsRegOnly, .pixelClk);
  pixel_src i_pix (.pixelClk);
  // ------
  // tasks
  // ------
  task ck(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    tick(1);
    regWrEn <= 1'b0;
  endtask
  task rc(logic [7:0] a, logic [7:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    tick(1);
    regRdEn <= 1'b0;
    ck($sformatf("reg %h", a), e, regRdData);
  endtask
  task errs(int n);
    repeat (n) begin
      @(posedge core_clk);
      bcCrcErr <= 2'b10;
      @(posedge core_clk);
      bcCrcErr <= 2'b00;
    end
  endtask
  task cnt(logic v, output int n);
    n = 0;
    while (sclOe === v && n < 400) begin
      tick(1);
      n++;
    end
  endtask
  task t_regs();
    foreach (rstVal[i]) rc(8'h17 + 8'(i), rstVal[i]);
    wr(8'h1a, 8'hfc);
    rc(8'h1a, 8'h00);
    wr(8'h1b, 8'h5a);
    rc(8'h1b, 8'h00);
    wr(8'h20, 8'h5a);
    rc(8'h20, 8'h00);
  endtask
  task t_fwd();
    accessId <= 7'h55;
    wr(8'h17, 8'h9e);
    ck("fwd", 8'h01, 8'(forwardAccess));
    wr(8'h17, 8'h1e);
    ck("fwd", 8'h00, 8'(forwardAccess));
    accessId <= 7'h20;
    tick(1);
    ck("fwd", 8'h01, 8'(forwardAccess));
    wr(8'h1e, 8'h07);
    accessId <= 7'h11;
    viaSecondAddr <= 1'b1;
    tick(1);
    ck("own2", 8'h01, 8'(isOwnSecond));
    ck("rdPort1", 8'h01, 8'(rdPort1));
    viaSecondAddr <= 1'b0;
    tick(1);
    ck("rdPort1", 8'h00, 8'(rdPort1));
    wr(8'h1e, 8'h03);
    ck("wrPort1En", 8'h01, 8'(wrPort1En));
    ck("rdPort1", 8'h01, 8'(rdPort1));
    wr(8'h1e, 8'h01);
    ck("rdPort1", 8'h00, 8'(rdPort1));
  endtask
  task t_pins();
    pinsRegOnly <= 4'hf;
    pinsPrimary <= 4'h5;
    pinsSecond <= 4'ha;
    tick(5);
    rc(8'h1c, 8'he5);
    rc(8'h1d, 8'h01);
    wr(8'h1e, 8'h02);
    rc(8'h1c, 8'hea);
  endtask
  task t_err();
    bistActive <= 1'b1;
    errs(3);
    rc(8'h1b, 8'h03);
    errs(300);
    rc(8'h1b, 8'hff);
    wr(8'h1e, 8'h01);
    rc(8'h1b, 8'h00);
    errClear <= 1'b1;
    tick(1);
    errClear <= 1'b0;
    wr(8'h1e, 8'h02);
    rc(8'h1b, 8'h00);
  endtask
  task t_scl();
    int n;
    wr(8'h18, 8'h00);
    wr(8'h19, 8'h00);
    masterEn <= 1'b1;
    cnt(1'b0, n);
    cnt(1'b1, n);
    ck("low", 8'h0a, 8'(n));
    cnt(1'b0, n);
    ck("high", 8'h0a, 8'(n));
    masterEn <= 1'b0;
    tick(40);
    ck("filt", 8'h03, 8'({sclFiltered, sdaFiltered}));
    stretchReq <= 1'b1;
    tick(3);
    stretchReq <= 1'b0;
    cnt(1'b1, n);
    ck("stretch", 8'h0a, 8'(n));
  endtask
  task t_audio();
    wr(8'h1a, 8'h03);
    tick(2);
    ck("wide", 8'h01, 8'(wideWordMode));
    ck("surr", 8'h01, 8'(surroundActive));
    frameTransportSel <= 1'b1;
    tick(2);
    ck("surr", 8'h00, 8'(surroundActive));
    frameTransportSel <= 1'b0;
    repeaterMode <= 1'b1;
    inbandModeValid <= 1'b1;
    rc(8'h1a, 8'h02);
    repeaterMode <= 1'b0;
    chanBEnable <= 1'b1;
    chanBOverride <= 1'b1;
    tick(2);
    ck("four", 8'h01, 8'(fourChannelActive));
  endtask
  task t_freq();
    wr(8'h1f, 8'h7d);
    tick(270);
    rc(8'h1f, 8'h32);
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ------
  // run
  // ------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    fails++;
    end_sim();
  end
  initial begin
    {rst_b, regWrEn, regRdEn, viaSecondAddr, regAddr, regWrData, accessId} = '0;
    {masterEn, stretchReq, chanBEnable, chanBOverride, frameTransportSel} = '0;
    {repeaterMode, inbandModeValid, inbandSurround, bistActive, bistStart} = '0;
    {errClear, bcCrcErr, pinsPrimary, pinsSecond, pinsRegOnly} = '0;
    {deviceId, remoteDesId, remoteTargetId, sdaIn} = {7'h10, 7'h20, 7'h30, 1'b1};
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_fwd();
    t_pins();
    t_err();
    t_scl();
    t_audio();
    t_freq();
    end_sim();
  end
endmodule
bind serializer_link_control_regs link_ctrl_chk i_chk (.core_clk, .rst_b, .accessId,
  .deviceId, .remoteDesId, .isOwnPrimary, .isOwnSecond, .forwardAccess, .rdPort1,
  .gpioCfgPort1, .stretchReq, .sclOe, .frameTransportSel, .wideWordMode, .lowSpeedCtrlEn,
  .surroundActive);
